// ### core/kps_scan_cfg.sv
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module kps_scan_cfg
  import kps_pkg::*;
#(
  parameter int STEP_CYCLES = KPS_STEP_CYCLES
)
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ce_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [KPS_ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // keypad and neighbouring event sources
  input  wire logic                  key_detect_i,
  input  wire logic                  calendar_event_i,
  input  wire logic                  serial_bus_event_i,
  input  wire logic [KPS_NUM_ROWS-1:0] row_i,
  // keypad drive and status
  output logic      [KPS_NUM_COLS-1:0] col_drive_o,
  output logic      [KPS_NUM_ROWS-1:0] row_enable_o,
  output logic                       powerdown_mux_select_o,
  output logic                       keypad_irq_o,
  output logic                       irq_o
);

  // ****************************************
  // bus decode
  // ****************************************
  logic        req;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] idx;
  logic        mapped;
  logic        byte0;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;
  assign idx    = wb_adr_i[KPS_ADDR_W-1:2];
  assign byte0  = wb_sel_i[0];
  assign mapped = (idx == KPS_IDX_DIMENSIONS) || (idx == KPS_IDX_ORDER_LOW) ||
                  (idx == KPS_IDX_ORDER_HIGH) || (idx == KPS_IDX_AUX_IRQ) ||
                  (idx == KPS_IDX_SCAN_CTRL)  || (idx == KPS_IDX_IRQ_STATUS) ||
                  (idx == KPS_IDX_IRQ_MASK);
  assign wr_stb = req && mapped && wb_we_i && byte0;
  assign rd_stb = req && mapped && !wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0]                 dims_q;
  logic [7:0]                 order_lo_q;
  logic [KPS_ORDER_HI_W-1:0]  order_hi_q;
  logic                       auto_scan_enable_q;
  logic                       key_found_irq_en_q;
  logic                       keypad_irq_enable_q;
  logic                       serial_bus_irq_enable_q;
  logic                       calendar_irq_enable_q;
  logic                       powerdown_mux_select_q;
  logic [KPS_EV_W-1:0]        ev_mask_q;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      dims_q                  <= KPS_RST_BYTE;
      order_lo_q              <= KPS_RST_BYTE;
      order_hi_q              <= KPS_RST_BYTE[KPS_ORDER_HI_W-1:0];
      auto_scan_enable_q      <= 1'b0;
      key_found_irq_en_q      <= 1'b0;
      keypad_irq_enable_q     <= 1'b0;
      serial_bus_irq_enable_q <= 1'b0;
      calendar_irq_enable_q   <= 1'b0;
      powerdown_mux_select_q  <= 1'b0;
      ev_mask_q               <= '0;
    end
    else if (ce_i && wr_stb)
    begin
      case (idx)
        KPS_IDX_DIMENSIONS: dims_q     <= wb_dat_i[7:0];
        KPS_IDX_ORDER_LOW:  order_lo_q <= wb_dat_i[7:0];
        KPS_IDX_ORDER_HIGH: order_hi_q <= wb_dat_i[KPS_ORDER_HI_W-1:0];
        KPS_IDX_SCAN_CTRL:
        begin
          auto_scan_enable_q <= wb_dat_i[KPS_CTRL_AUTO];
          key_found_irq_en_q <= wb_dat_i[KPS_CTRL_DET_EN];
        end
        KPS_IDX_AUX_IRQ:
        begin
          keypad_irq_enable_q     <= wb_dat_i[KPS_AUX_KP_EN];
          serial_bus_irq_enable_q <= wb_dat_i[KPS_AUX_SB_EN];
          calendar_irq_enable_q   <= wb_dat_i[KPS_AUX_CAL_EN];
          powerdown_mux_select_q  <= wb_dat_i[KPS_AUX_PD_MUX];
        end
        KPS_IDX_IRQ_MASK:   ev_mask_q <= wb_dat_i[KPS_EV_W-1:0];
        default:            ;
      endcase
    end
  end

  // ****************************************
  // scan order slots
  // ****************************************
  logic [14:0]     order_all;
  logic [2:0]      slot_col [KPS_NUM_SLOTS];
  kps_size_t       size;
  logic [2:0]      used_row_count;
  logic [2:0]      used_column_count;

  assign order_all = {order_hi_q, order_lo_q};
  assign size      = kps_size_t'({dims_q[KPS_ROW_LSB+:3], dims_q[KPS_COL_LSB+:3]});
  // zero or oversize counts fall back to the package maximum so the scanner never stalls
  assign used_row_count    = (size.rows == 3'h0 || size.rows > KPS_MAX_ROWS) ? KPS_MAX_ROWS : size.rows;
  assign used_column_count = (size.cols == 3'h0 || size.cols > KPS_MAX_COLS) ? KPS_MAX_COLS : size.cols;

  genvar gs;
  generate
    for (gs = 0; gs < KPS_NUM_SLOTS; gs++)
    begin : g_slot
      assign slot_col[gs] = order_all[gs*KPS_SLOT_W +: KPS_SLOT_W];
    end
  endgenerate

  // ****************************************
  // scan sequencer
  // ****************************************
  kps_state_t  state_q;
  logic [2:0]  slot_q;
  logic [31:0] tick_q;
  logic        step;
  logic        wrap_ev;

  assign step    = (state_q == KPS_ST_SCAN) && (tick_q == 32'(STEP_CYCLES - 1));
  assign wrap_ev = step && (slot_q >= used_column_count - 3'h1);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= KPS_ST_IDLE;
      slot_q  <= 3'h0;
      tick_q  <= '0;
    end
    else if (ce_i)
    begin
      case (state_q)
        KPS_ST_IDLE:
        begin
          slot_q <= 3'h0;
          tick_q <= '0;
          if (auto_scan_enable_q)
            state_q <= KPS_ST_SCAN;
        end
        KPS_ST_SCAN:
        begin
          if (!auto_scan_enable_q)
            state_q <= KPS_ST_IDLE;
          else if (step)
          begin
            tick_q <= '0;
            slot_q <= wrap_ev ? 3'h0 : slot_q + 3'h1;
          end
          else
            tick_q <= tick_q + 32'h1;
        end
        default: state_q <= KPS_ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // column and row drive
  // ****************************************
  logic [2:0] cur_col;
  assign cur_col = slot_col[slot_q];

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      col_drive_o  <= '0;
      row_enable_o <= '0;
    end
    else if (ce_i)
    begin
      col_drive_o  <= '0;
      row_enable_o <= '0;
      if (state_q == KPS_ST_SCAN)
      begin
        // a slot naming a column past the last pin drives nothing
        if (cur_col < KPS_MAX_COLS)
          col_drive_o[cur_col] <= 1'b1;
        for (int r = 0; r < KPS_NUM_ROWS; r++)
          row_enable_o[r] <= (3'(r) < used_row_count);
      end
    end
  end

  // ****************************************
  // flags, cleared on read
  // ****************************************
  logic       key_found_flag_q;
  logic       keypad_irq_flag_q;
  logic       calendar_irq_flag_q;
  logic       serial_bus_irq_flag_q;
  logic       rd_ctrl;
  logic       rd_aux;

  assign rd_ctrl = rd_stb && (idx == KPS_IDX_SCAN_CTRL);
  assign rd_aux  = rd_stb && (idx == KPS_IDX_AUX_IRQ);

  // set wins over a read in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      key_found_flag_q      <= 1'b0;
      keypad_irq_flag_q     <= 1'b0;
      calendar_irq_flag_q   <= 1'b0;
      serial_bus_irq_flag_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (key_detect_i)
        key_found_flag_q <= 1'b1;
      else if (rd_ctrl)
        key_found_flag_q <= 1'b0;
      if (key_detect_i)
        keypad_irq_flag_q <= 1'b1;
      else if (rd_aux)
        keypad_irq_flag_q <= 1'b0;
      if (calendar_event_i)
        calendar_irq_flag_q <= 1'b1;
      else if (rd_aux)
        calendar_irq_flag_q <= 1'b0;
      if (serial_bus_event_i)
        serial_bus_irq_flag_q <= 1'b1;
      else if (rd_aux)
        serial_bus_irq_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // sticky status, mask, interrupt
  // ****************************************
  logic [KPS_EV_W-1:0] ev_stat_q;
  logic [KPS_EV_W-1:0] ev_set;
  logic [KPS_EV_W-1:0] ev_clr;

  assign ev_set = {wrap_ev, serial_bus_event_i, calendar_event_i, key_detect_i};
  assign ev_clr = (wr_stb && idx == KPS_IDX_IRQ_STATUS) ? wb_dat_i[KPS_EV_W-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ev_stat_q <= '0;
    else if (ce_i)
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
  end

  assign keypad_irq_o = (keypad_irq_flag_q && keypad_irq_enable_q) ||
                        (calendar_irq_flag_q && calendar_irq_enable_q) ||
                        (serial_bus_irq_flag_q && serial_bus_irq_enable_q) ||
                        (key_found_flag_q && key_found_irq_en_q);
  assign irq_o        = |(ev_stat_q & ev_mask_q);
  assign powerdown_mux_select_o = powerdown_mux_select_q;

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      wb_dat_o <= '0;
    else if (ce_i && req)
    begin
      wb_dat_o <= '0;
      case (idx)
        KPS_IDX_DIMENSIONS: wb_dat_o[7:0] <= {2'b00, dims_q[5:0]};
        KPS_IDX_ORDER_LOW:  wb_dat_o[7:0] <= order_lo_q;
        KPS_IDX_ORDER_HIGH: wb_dat_o[KPS_ORDER_HI_W-1:0] <= order_hi_q;
        KPS_IDX_SCAN_CTRL:
          wb_dat_o[3:0] <= {tick_q < 32'(STEP_CYCLES / 2) && state_q == KPS_ST_SCAN,
                            auto_scan_enable_q, key_found_flag_q, key_found_irq_en_q};
        KPS_IDX_AUX_IRQ:
          wb_dat_o[7:0] <= {powerdown_mux_select_q, 1'b0, calendar_irq_enable_q, calendar_irq_flag_q,
                            serial_bus_irq_enable_q, serial_bus_irq_flag_q, keypad_irq_enable_q,
                            keypad_irq_flag_q};
        KPS_IDX_IRQ_STATUS: wb_dat_o[KPS_EV_W-1:0] <= ev_stat_q;
        KPS_IDX_IRQ_MASK:   wb_dat_o[KPS_EV_W-1:0] <= ev_mask_q;
        default:            ;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_aux_read;
    ce_i && rd_aux && !key_detect_i;
  endsequence

  chk_kp_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && key_detect_i |=> keypad_irq_flag_q)
    else $error("keypad flag not set by key detect");
  chk_kp_flag_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_aux_read |=> !keypad_irq_flag_q)
    else $error("keypad flag not cleared by read");
  chk_kp_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    keypad_irq_flag_q && keypad_irq_enable_q |-> keypad_irq_o)
    else $error("enabled keypad flag not forwarded");
  chk_cal_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && rd_aux && !calendar_event_i |=> !calendar_irq_flag_q)
    else $error("calendar flag not cleared by read");
  chk_found_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && rd_ctrl && !key_detect_i |=> !key_found_flag_q)
    else $error("key found flag not cleared by read");
  chk_one_col: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $onehot0(col_drive_o))
    else $error("more than one column driven");
  chk_idle_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !auto_scan_enable_q && state_q == KPS_ST_IDLE |=> col_drive_o == '0)
    else $error("column driven without auto scan");
  chk_slot_wrap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && wrap_ev && auto_scan_enable_q |=> slot_q == 3'h0)
    else $error("scan did not wrap to first slot");
  chk_slot_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == KPS_ST_SCAN && $stable(dims_q) |-> slot_q < used_column_count)
    else $error("slot beyond column count");

endmodule

// ### core/kps_pkg.sv
package kps_pkg;

  // ****************************************
  // register map
  // ****************************************
  // printed offsets are not all multiples of four: they are indices, byte address is four times the index
  localparam logic [15:0] KPS_IDX_DIMENSIONS = 16'h00d5;
  localparam logic [15:0] KPS_IDX_ORDER_LOW  = 16'h00d6;
  localparam logic [15:0] KPS_IDX_ORDER_HIGH = 16'h00d7;
  localparam logic [15:0] KPS_IDX_AUX_IRQ    = 16'hff94;
  localparam logic [15:0] KPS_IDX_SCAN_CTRL  = 16'h00d4;
  localparam logic [15:0] KPS_IDX_IRQ_STATUS = 16'h0100;
  localparam logic [15:0] KPS_IDX_IRQ_MASK   = 16'h0101;
  localparam int          KPS_ADDR_W         = 18;

  localparam logic [7:0] KPS_RST_BYTE = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int KPS_COL_LSB     = 0;
  localparam int KPS_ROW_LSB     = 3;
  localparam int KPS_SLOT_W      = 3;
  localparam int KPS_NUM_SLOTS   = 5;
  localparam logic [2:0] KPS_MAX_ROWS = 3'h6;
  localparam logic [2:0] KPS_MAX_COLS = 3'h5;
  localparam int KPS_NUM_COLS    = 5;
  localparam int KPS_NUM_ROWS    = 6;
  localparam int KPS_ORDER_HI_W  = 7;

  localparam int KPS_AUX_KP_FLAG  = 0;
  localparam int KPS_AUX_KP_EN    = 1;
  localparam int KPS_AUX_SB_FLAG  = 2;
  localparam int KPS_AUX_SB_EN    = 3;
  localparam int KPS_AUX_CAL_FLAG = 4;
  localparam int KPS_AUX_CAL_EN   = 5;
  localparam int KPS_AUX_PD_MUX   = 7;

  localparam int KPS_CTRL_DET_EN  = 0;
  localparam int KPS_CTRL_DET     = 1;
  localparam int KPS_CTRL_AUTO    = 2;
  localparam int KPS_CTRL_KEYCLK  = 3;

  // event bits of the sticky status and mask registers
  localparam int KPS_EV_KEY   = 0;
  localparam int KPS_EV_CAL   = 1;
  localparam int KPS_EV_SB    = 2;
  localparam int KPS_EV_WRAP  = 3;
  localparam int KPS_EV_W     = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int KPS_CLK_MHZ      = 100;
  localparam int KPS_STEP_US      = 1000;
  localparam int KPS_STEP_CYCLES  = KPS_STEP_US * KPS_CLK_MHZ;

  typedef enum logic [1:0]
  {
    KPS_ST_IDLE = 2'b00,
    KPS_ST_SCAN = 2'b01
  } kps_state_t;

  typedef struct packed
  {
    logic [2:0] rows;
    logic [2:0] cols;
  } kps_size_t;

endpackage

// ### verif/kps_keypad_model.sv
`timescale 1ns/1ps
module kps_keypad_model
  import kps_pkg::*;
(
  // key under test
  input  wire logic                    press_i,
  input  wire logic [2:0]              row_sel_i,
  input  wire logic [2:0]              col_sel_i,
  // matrix lines
  input  wire logic [KPS_NUM_COLS-1:0] col_drive_i,
  output logic      [KPS_NUM_ROWS-1:0] row_o
);
  // rows idle high through pull-ups; a closed switch pulls its row low only while its column is driven
  always_comb
  begin
    row_o = '1;
    if (press_i && col_drive_i[col_sel_i])
      row_o[row_sel_i] = 1'b0;
  end
endmodule

// ### verif/kps_scan_cfg_test.sv
`timescale 1ns/1ps
module kps_scan_cfg_test
  import kps_pkg::*;
();
  localparam int STEP = 4;
  logic        clk_i, rstn_i, cyc, stb, we, ack, err, kd, cal, sb, pdm, kirq, irq, last_err, press, ce;
  logic [17:0] adr;
  logic [31:0] wdat, rdat;
  logic [5:0]  rows, row_en;
  logic [4:0]  cols;
  logic [7:0]  rd, d0, d1, d2;
  logic [14:0] order;
  logic [2:0]  sl [5];
  logic [2:0]  tmp;
  logic [7:0]  szt [4] = '{8'h11, 8'h33, 8'h05, 8'h20};
  logic [15:0] rst_idx [6];
  int          error_cnt, n_tests, n, j, nc;

  kps_scan_cfg #(.STEP_CYCLES(STEP)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .key_detect_i(kd), .calendar_event_i(cal), .serial_bus_event_i(sb),
    .row_i(rows), .col_drive_o(cols), .row_enable_o(row_en), .powerdown_mux_select_o(pdm),
    .keypad_irq_o(kirq), .irq_o(irq));

  kps_keypad_model pad (.press_i(press), .row_sel_i(3'h2), .col_sel_i(sl[0]), .col_drive_i(cols), .row_o(rows));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // classic single cycle; request held until ack or err is sampled
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(k < 50, 1);
    rd = rdat[7:0];
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] m, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd & m, exp & m);
  endtask

  // events as {key, calendar, serial bus}
  task automatic ev(input logic [2:0] v);
    @(posedge clk_i);
    {kd, cal, sb} <= v;
    @(posedge clk_i);
    {kd, cal, sb} <= 3'b000;
    @(posedge clk_i);
  endtask

  function automatic logic [4:0] col_exp(input logic [14:0] o, input int s);
    logic [2:0] v;
    v = o[3*s +: 3];
    return (v < 3'h5) ? (5'h01 << v) : 5'h00;
  endfunction

  function automatic logic [5:0] row_exp(input logic [2:0] r);
    logic [2:0] c;
    c = (r == 3'h0 || r > 3'h6) ? 3'h6 : r;
    return 6'h3f >> (3'h6 - c);
  endfunction

  // ****************************************
  // clock, reset, watchdog
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (50000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    {rstn_i, cyc, stb, we, kd, cal, sb, press} = '0;
    ce = 1'b1;
    adr = '0;
    wdat = '0;
    error_cnt = 0;
    n_tests = 0;
    rst_idx = '{KPS_IDX_DIMENSIONS, KPS_IDX_ORDER_LOW, KPS_IDX_ORDER_HIGH, KPS_IDX_AUX_IRQ,
                KPS_IDX_IRQ_STATUS, KPS_IDX_IRQ_MASK};
    for (int i = 0; i < 5; i++)
      sl[i] = 3'(i);
    void'($urandom(32'haec8));
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd_chk(rst_idx[i], 8'hff, 8'h00);
    wb(1'b0, 16'h0050, 8'h00);
    chk(last_err, 1'b1);
    repeat (8)
    begin
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      wb(1'b1, KPS_IDX_DIMENSIONS, d0);
      wb(1'b1, KPS_IDX_ORDER_LOW, d1);
      wb(1'b1, KPS_IDX_ORDER_HIGH, d2);
      rd_chk(KPS_IDX_DIMENSIONS, 8'h3f, d0);
      rd_chk(KPS_IDX_ORDER_LOW, 8'hff, d1);
      rd_chk(KPS_IDX_ORDER_HIGH, 8'h7f, d2);
    end
    // flags, enables and powerdown select share one register
    wb(1'b1, KPS_IDX_AUX_IRQ, 8'haa);
    @(posedge clk_i);
    chk(pdm, 1'b1);
    chk(kirq, 1'b0);
    ev(3'b111);
    chk(kirq, 1'b1);
    rd_chk(KPS_IDX_AUX_IRQ, 8'hff, 8'hbf);
    rd_chk(KPS_IDX_AUX_IRQ, 8'hff, 8'haa);
    @(posedge clk_i);
    chk(kirq, 1'b0);
    wb(1'b1, KPS_IDX_AUX_IRQ, 8'h00);
    ev(3'b100);
    chk(kirq, 1'b0);
    rd_chk(KPS_IDX_AUX_IRQ, 8'hff, 8'h01);
    rd_chk(KPS_IDX_SCAN_CTRL, 8'h07, 8'h02);
    rd_chk(KPS_IDX_SCAN_CTRL, 8'h07, 8'h00);
    // random distinct column per slot, so every step is told apart
    for (int i = 4; i > 0; i--)
    begin
      j = int'($urandom % (i + 1));
      tmp = sl[i];
      sl[i] = sl[j];
      sl[j] = tmp;
    end
    for (int i = 0; i < 5; i++)
      order[3*i +: 3] = sl[i];
    press <= 1'b1;
    for (int t = 0; t < 4; t++)
    begin
      wb(1'b1, KPS_IDX_ORDER_LOW, order[7:0]);
      wb(1'b1, KPS_IDX_ORDER_HIGH, {1'b0, order[14:8]});
      wb(1'b1, KPS_IDX_DIMENSIONS, szt[t]);
      wb(1'b1, KPS_IDX_SCAN_CTRL, 8'h04);
      nc = (szt[t][2:0] == 3'h0 || szt[t][2:0] > 3'h5) ? 5 : int'(szt[t][2:0]);
      n = 0;
      while (cols === 5'h00 && n < 100)
      begin
        @(posedge clk_i);
        n++;
      end
      chk(n < 100, 1);
      @(posedge clk_i);
      chk(row_en, row_exp(szt[t][5:3]));
      for (int k = 0; k < 2 * nc; k++)
      begin
        chk(cols, col_exp(order, k % nc));
        chk(rows, (k % nc == 0) ? 6'h3b : 6'h3f);
        repeat (STEP) @(posedge clk_i);
      end
      wb(1'b1, KPS_IDX_SCAN_CTRL, 8'h00);
      repeat (3) @(posedge clk_i);
      chk(cols, 5'h00);
      chk(row_en, 6'h00);
    end
    press <= 1'b0;
    // sticky status, mask and the level interrupt
    wb(1'b1, KPS_IDX_IRQ_STATUS, 8'h0f);
    wb(1'b1, KPS_IDX_IRQ_MASK, 8'h00);
    // events while the clock enable is low must leave the sticky status untouched
    ce <= 1'b0;
    ev(3'b111);
    ce <= 1'b1;
    rd_chk(KPS_IDX_IRQ_STATUS, 8'hff, 8'h00);
    ev(3'b111);
    rd_chk(KPS_IDX_IRQ_STATUS, 8'hff, 8'h07);
    chk(irq, 1'b0);
    wb(1'b1, KPS_IDX_IRQ_MASK, 8'h04);
    @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b1, KPS_IDX_IRQ_STATUS, 8'h04);
    @(posedge clk_i);
    chk(irq, 1'b0);
    rd_chk(KPS_IDX_IRQ_STATUS, 8'hff, 8'h03);
    end_of_test();
  end
endmodule
